/* File: src/sarrd_params.svh */
// sarrd_params.svh: offsets, field positions and timing figures of the
// sar readout block; definitions only, included by the package and the top.
`ifndef SARRD_PARAMS_SVH
`define SARRD_PARAMS_SVH

// register byte offsets on the apb bus
`define SARRD_OFF_CTRL      8'h00
`define SARRD_OFF_TEST      8'h04
`define SARRD_OFF_STATUS    8'h08
`define SARRD_OFF_RESULT    8'h0C
`define SARRD_OFF_COUNT     8'h10
// control fields
`define SARRD_CTRL_BLOCK    0
`define SARRD_CTRL_TEST     1
`define SARRD_CTRL_W        2
// status fields
`define SARRD_ST_STATE_LO   0
`define SARRD_ST_MODE       2
`define SARRD_ST_STANDBY_REQUEST       3
`define SARRD_ST_NAP        4
`define SARRD_ST_OE         5
`define SARRD_ST_HOLD       6
// synchronised pin indices
`define SARRD_IN_MCLK       0
`define SARRD_IN_TRIG       1
`define SARRD_IN_FS         2
`define SARRD_IN_MODE       3
`define SARRD_IN_STANDBY_REQUEST       4
`define SARRD_IN_NAP        5
`define SARRD_IN_RST        6
`define SARRD_NIN           7
// frame and data widths, timing
`define SARRD_RES_BITS      14
`define SARRD_WORD_BITS     15
`define SARRD_FRAME_BITS    16
`define SARRD_CONV_PERIODS  24
`define SARRD_ACQ_NS        70
`define SARRD_CLK_MHZ       50

`endif

/* File: src/sarrd_pkg.sv */
// sarrd_pkg: types of the sar readout block.
// assumes sarrd_params.svh is on the include path.
`include "sarrd_params.svh"

package sarrd_pkg;

    // conversion sequencer states
    typedef enum logic [1:0] {ST_TRACK, ST_CONV, ST_ACQ, ST_DOWN} sarrd_state_t;

    // whole state of the block, registered in one process
    typedef struct packed {
        logic [`SARRD_NIN-1:0]        s1;
        logic [`SARRD_NIN-1:0]        s2;
        logic [`SARRD_NIN-1:0]        s3;
        logic [`SARRD_NIN-1:0]        fin;
        sarrd_state_t                 state;
        logic [4:0]                   conv_cnt;
        logic [2:0]                   acq_cnt;
        logic [`SARRD_WORD_BITS-1:0]  hold_data;
        logic [`SARRD_WORD_BITS-1:0]  sar;
        logic [`SARRD_WORD_BITS-1:0]  test_data;
        logic [`SARRD_FRAME_BITS-1:0] shreg;
        logic [4:0]                   bit_cnt;
        logic                         armed;
        logic                         sending;
        logic                         serial_data_out;
        logic                         sdo_oe;
        logic                         serial_clock_out;
        logic                         th_hold;
        logic [`SARRD_CTRL_W-1:0]     ctrl;
        logic [15:0]                  conv_count;
        logic [31:0]                  prdata;
        logic                         pready;
        logic                         pslverr;
    } sarrd_regs_t;

endpackage : sarrd_pkg

/* File: src/sarrd_top.sv */
// sarrd_top: conversion sequencer and serial readout of a 14-bit sar adc,
// with an apb register slave. the seven adc control pins arrive asynchronously to sys_clk_i;
// the master clock pin is much slower than sys_clk_i and is sampled.
//
// Overview of operation
// RULE1 - standby request high keeps the block powered down
// RULE2 - nap request high keeps the block in nap
// RULE3 - host master clock runs no faster than 25 MHz; the sampling here follows it only up to 12.5 MHz
// RULE4 - a conversion lasts 24 master clock periods from trigger fall
// RULE5 - serial data changes on rising serial clock edges
// RULE6 - host samples serial data on falling serial clock edges
// RULE7 - frame: overrange, 14 result bits msb first, trailing zero
// RULE8 - mode 2: frame sync fall enables output, frame at next rise
// RULE9 - mode select low gives mode 1, high gives mode 2
// RULE10 - serial clock out is derived from the master clock
// RULE11 - trigger fall switches track to hold and starts conversion
// RULE12 - reset pin fall aborts conversion and reinitialises state
// RULE13 - reset pin held low keeps the block in reset
// RULE14 - conversion end returns to track, 70 ns acquisition follows
// RULE15 - completed result is held once the bit trials finish
// RULE16 - each frame carries the previous conversion result
// RULE17 - mode 1: host holds trigger low 22 serial clocks
// RULE18 - mode 2: frame sync low 22 serial clocks or tied low
// RULE19 - mode 2 idling high: trigger low pulse 10 ns to two periods; the synchroniser here needs it low for two 20 ns system clocks
// RULE20 - no new trigger until conversion and acquisition complete
`timescale 1ns/1ps
`default_nettype none
`include "sarrd_params.svh"

module sarrd_top
    import sarrd_pkg::*;
#(
    parameter int CONV_PERIODS = `SARRD_CONV_PERIODS, // master clocks per conversion
    parameter int ACQ_NS       = `SARRD_ACQ_NS        // acquisition time in ns
) (
    input  wire logic        sys_clk_i,              // 50 MHz system clock
    input  wire logic        rstn_i,                 // sync reset, active low
    input  wire logic [7:0]  paddr_i,                // apb address
    input  wire logic        psel_i,                 // apb select
    input  wire logic        penable_i,              // apb enable
    input  wire logic        pwrite_i,               // apb write
    input  wire logic [31:0] pwdata_i,               // apb write data
    output logic      [31:0] prdata_o,               // apb read data
    output logic             pready_o,               // apb ready
    output logic             pslverr_o,              // apb error, unmapped
    input  wire logic        master_clock_i,         // host master clock pin
    input  wire logic        conversion_trigger_n_i, // convert start, active low
    input  wire logic        frame_sync_in_i,        // frame sync, mode 2
    input  wire logic        serial_mode_select_i,   // low mode 1, high mode 2
    input  wire logic        standby_request_i,      // standby request pin
    input  wire logic        nap_request_i,          // nap request pin
    input  wire logic        adc_reset_n_i,          // reset pin, active low
    input  wire logic [13:0] sample_code_i,          // quantiser code
    input  wire logic        overrange_i,            // quantiser overrange
    output logic             serial_clock_out_o,     // serial clock out
    output logic             serial_data_out_o,      // serial data out
    output logic             serial_data_oe_o,       // serial data drive enable
    output logic             track_hold_o,           // high while holding
    output logic             standby_o,              // standby mode active
    output logic             nap_o                   // nap mode active
);

    // acquisition rounded up to whole system clocks
    localparam int ACQ_CYC = (ACQ_NS * `SARRD_CLK_MHZ + 999) / 1000;
    localparam int LAST_BIT = `SARRD_FRAME_BITS - 1;

    // elaboration checks: counters are 5 and 3 bits wide
    if (CONV_PERIODS < 1 || CONV_PERIODS > 31) begin : g_chk_conv
        $error("CONV_PERIODS out of range");
    end
    if (ACQ_CYC < 1 || ACQ_CYC > 7) begin : g_chk_acq
        $error("ACQ_NS out of range");
    end

    sarrd_regs_t q;
    sarrd_regs_t next_q;

    // falling edge between old and new filtered level
    function automatic logic fell(input logic old_v, input logic new_v);
        return old_v & ~new_v;
    endfunction : fell

    // address lies on a mapped register
    function automatic logic mapped(input logic [7:0] a);
        return a == `SARRD_OFF_CTRL || a == `SARRD_OFF_TEST ||
               a == `SARRD_OFF_STATUS || a == `SARRD_OFF_RESULT ||
               a == `SARRD_OFF_COUNT;
    endfunction : mapped

    logic sco_rise;
    logic trig_fall;
    logic fs_fall;
    logic powered;
    logic mode2;

    // next-state logic of the whole block
    always_comb begin
        next_q = q;
        // three-stage synchronisers, first stage read only by the second
        next_q.s1 = {adc_reset_n_i, nap_request_i, standby_request_i,
                     serial_mode_select_i, frame_sync_in_i,
                     conversion_trigger_n_i, master_clock_i};
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        // a level counts once stages two and three agree
        next_q.fin = (q.s2 & q.s3) | (q.fin & (q.s2 ^ q.s3));

        trig_fall = fell(q.fin[`SARRD_IN_TRIG], next_q.fin[`SARRD_IN_TRIG]);
        fs_fall   = fell(q.fin[`SARRD_IN_FS], next_q.fin[`SARRD_IN_FS]);
        mode2     = next_q.fin[`SARRD_IN_MODE]; // RULE9
        powered   = ~next_q.fin[`SARRD_IN_STANDBY_REQUEST] & ~next_q.fin[`SARRD_IN_NAP];

        // serial clock follows the master clock, stopped when powered down
        next_q.serial_clock_out = next_q.fin[`SARRD_IN_MCLK] & powered; // RULE10
        sco_rise   = next_q.serial_clock_out & ~q.serial_clock_out;

        // shift out on rising serial clock only; sdo holds otherwise
        if (sco_rise) begin
            if (q.armed) begin
                next_q.serial_data_out     = q.shreg[LAST_BIT]; // RULE5 RULE7
                next_q.shreg   = {q.shreg[LAST_BIT-1:0], 1'b0};
                next_q.bit_cnt = 5'h01;
                next_q.sending = 1'b1;
                next_q.armed   = 1'b0;
            end else if (q.sending) begin
                next_q.serial_data_out     = q.shreg[LAST_BIT]; // RULE5 RULE7
                next_q.shreg   = {q.shreg[LAST_BIT-1:0], 1'b0};
                next_q.bit_cnt = q.bit_cnt + 5'h01;
                if (q.bit_cnt == 5'(LAST_BIT)) begin
                    next_q.sending = 1'b0;
                end
            end
        end

        // mode 2 frame sync fall starts a frame at the next rise
        if (mode2 && fs_fall) begin
            next_q.armed = 1'b1; // RULE8
        end

        // conversion sequencer
        case (q.state)
            ST_TRACK: begin
                if (trig_fall && !q.ctrl[`SARRD_CTRL_BLOCK]) begin
                    next_q.state     = ST_CONV; // RULE11
                    next_q.th_hold   = 1'b1;
                    next_q.conv_cnt  = 5'h00;
                    next_q.hold_data = q.ctrl[`SARRD_CTRL_TEST] ? q.test_data
                                       : {overrange_i, sample_code_i};
                    // the frame carries the result finished before this one
                    next_q.shreg   = {q.sar, 1'b0}; // RULE16 RULE7
                    next_q.sending = 1'b0;
                    next_q.bit_cnt = 5'h00;
                    // mode 1 frames on the trigger; mode 2 only if sync is low
                    if (!mode2 || !next_q.fin[`SARRD_IN_FS]) begin
                        next_q.armed = 1'b1;
                    end
                end
            end
            ST_CONV: begin
                if (sco_rise) begin
                    if (q.conv_cnt == 5'(CONV_PERIODS - 1)) begin
                        next_q.state      = ST_ACQ; // RULE4
                        next_q.th_hold    = 1'b0; // RULE14
                        next_q.sar        = q.hold_data; // RULE15
                        next_q.conv_count = q.conv_count + 16'h0001;
                        next_q.acq_cnt    = 3'h0;
                    end else begin
                        next_q.conv_cnt = q.conv_cnt + 5'h01;
                    end
                end
            end
            ST_ACQ: begin
                // triggers are ignored until the input has settled
                if (q.acq_cnt == 3'(ACQ_CYC - 1)) begin
                    next_q.state = ST_TRACK; // RULE14
                end else begin
                    next_q.acq_cnt = q.acq_cnt + 3'h1;
                end
            end
            ST_DOWN: begin
                if (powered) begin
                    next_q.state = ST_TRACK;
                end
            end
            default: begin
                next_q.state = ST_TRACK;
            end
        endcase

        // power-down aborts any conversion and frame
        if (!powered) begin
            next_q.state   = ST_DOWN; // RULE1 RULE2
            next_q.th_hold = 1'b0;
            next_q.armed   = 1'b0;
            next_q.sending = 1'b0;
        end
        // reset pin wins over the sequencer and power-down while low
        if (!next_q.fin[`SARRD_IN_RST]) begin
            next_q.state   = ST_TRACK; // RULE12 RULE13
            next_q.th_hold = 1'b0;
            next_q.armed   = 1'b0;
            next_q.sending = 1'b0;
        end

        // output drive: trigger frames mode 1, frame sync frames mode 2
        next_q.sdo_oe = powered & next_q.fin[`SARRD_IN_RST] &
                        (mode2 ? ~next_q.fin[`SARRD_IN_FS]
                               : ~next_q.fin[`SARRD_IN_TRIG]); // RULE8 RULE9

        // apb: ready in the first access cycle, so no wait states
        next_q.pready  = psel_i & ~penable_i;
        next_q.pslverr = psel_i & ~penable_i & ~mapped(paddr_i);
        next_q.prdata  = 32'h0000_0000;
        if (psel_i && !penable_i && !pwrite_i) begin
            if (paddr_i == `SARRD_OFF_CTRL) begin
                next_q.prdata[`SARRD_CTRL_W-1:0] = q.ctrl;
            end else if (paddr_i == `SARRD_OFF_TEST) begin
                next_q.prdata[`SARRD_WORD_BITS-1:0] = q.test_data;
            end else if (paddr_i == `SARRD_OFF_STATUS) begin
                next_q.prdata[`SARRD_ST_STATE_LO+1:`SARRD_ST_STATE_LO] = q.state;
                next_q.prdata[`SARRD_ST_MODE] = q.fin[`SARRD_IN_MODE];
                next_q.prdata[`SARRD_ST_STANDBY_REQUEST] = q.fin[`SARRD_IN_STANDBY_REQUEST];
                next_q.prdata[`SARRD_ST_NAP]  = q.fin[`SARRD_IN_NAP];
                next_q.prdata[`SARRD_ST_OE]   = q.sdo_oe;
                next_q.prdata[`SARRD_ST_HOLD] = q.th_hold;
            end else if (paddr_i == `SARRD_OFF_RESULT) begin
                next_q.prdata[`SARRD_WORD_BITS-1:0] = q.sar;
            end else if (paddr_i == `SARRD_OFF_COUNT) begin
                next_q.prdata[15:0] = q.conv_count;
            end
        end
        // writes land on the completing access edge
        if (psel_i && penable_i && q.pready && pwrite_i) begin
            if (paddr_i == `SARRD_OFF_CTRL) begin
                next_q.ctrl = pwdata_i[`SARRD_CTRL_W-1:0];
            end else if (paddr_i == `SARRD_OFF_TEST) begin
                next_q.test_data = pwdata_i[`SARRD_WORD_BITS-1:0];
            end
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from flip-flops
    assign prdata_o           = q.prdata;
    assign pready_o           = q.pready;
    assign pslverr_o          = q.pslverr;
    assign serial_clock_out_o = q.serial_clock_out;
    assign serial_data_out_o  = q.serial_data_out;
    assign serial_data_oe_o   = q.sdo_oe;
    assign track_hold_o       = q.th_hold;
    assign standby_o          = q.fin[`SARRD_IN_STANDBY_REQUEST];
    assign nap_o              = q.fin[`SARRD_IN_NAP];

    // checks on the sequencer and the frame
    int conv_last;
    int acq_last;
    assign conv_last = CONV_PERIODS - 1;
    assign acq_last  = ACQ_CYC - 1;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_conv_start;
        $rose(q.state == ST_CONV);
    endsequence

    sequence s_conv_end;
        $past(q.state) == ST_CONV && q.state == ST_ACQ;
    endsequence

    chk_standby_down: assert property (q.fin[`SARRD_IN_STANDBY_REQUEST] && q.fin[`SARRD_IN_RST]
        |-> q.state == ST_DOWN && !q.th_hold) else $error("standby not honoured"); // RULE1
    chk_nap_down: assert property (q.fin[`SARRD_IN_NAP] && q.fin[`SARRD_IN_RST]
        |-> q.state == ST_DOWN && !q.sdo_oe) else $error("nap not honoured"); // RULE2
    chk_conv_length: assert property (s_conv_end
        |-> $rose(q.serial_clock_out) && $past(q.conv_cnt) == conv_last) else $error("bad conversion length"); // RULE4
    chk_sdo_on_rise: assert property ($changed(q.serial_data_out) |-> $rose(q.serial_clock_out))
        else $error("data changed off a rising serial clock"); // RULE5
    chk_frame_first: assert property ($rose(q.serial_clock_out) && $past(q.armed) && q.fin[`SARRD_IN_RST]
        |-> q.serial_data_out == $past(q.shreg[LAST_BIT]) && q.sending) else $error("bad first bit"); // RULE7
    chk_frame_tail: assert property ($rose(q.serial_clock_out) && $past(q.sending) && $past(q.bit_cnt) == LAST_BIT
        |-> !q.serial_data_out && !q.sending) else $error("trailing zero missing"); // RULE7
    chk_mode2_release: assert property (q.fin[`SARRD_IN_MODE] && $fell(q.fin[`SARRD_IN_FS])
        && q.state != ST_DOWN && q.fin[`SARRD_IN_RST] |-> q.sdo_oe && q.armed)
        else $error("frame sync did not release output"); // RULE8
    chk_mode1_float: assert property (!q.fin[`SARRD_IN_MODE] && q.fin[`SARRD_IN_TRIG]
        |-> !q.sdo_oe) else $error("mode 1 output driven while trigger high"); // RULE9
    chk_sco_follow: assert property (q.state != ST_DOWN && !q.fin[`SARRD_IN_STANDBY_REQUEST]
        && !q.fin[`SARRD_IN_NAP] |-> q.serial_clock_out == q.fin[`SARRD_IN_MCLK])
        else $error("serial clock not following master clock"); // RULE10
    chk_hold_start: assert property (s_conv_start
        |-> q.th_hold && $fell(q.fin[`SARRD_IN_TRIG]) && $past(q.state) == ST_TRACK)
        else $error("conversion start without trigger fall"); // RULE11
    chk_pin_reset: assert property (!q.fin[`SARRD_IN_RST]
        |-> q.state == ST_TRACK && !q.th_hold && !q.sdo_oe && !q.sending)
        else $error("reset pin not holding reset"); // RULE12
    chk_acq_time: assert property ($past(q.state) == ST_ACQ && q.state == ST_TRACK && q.fin[`SARRD_IN_RST]
        |-> $past(q.acq_cnt) == acq_last) else $error("acquisition cut short"); // RULE14
    chk_result_latch: assert property (s_conv_end
        |-> q.sar == $past(q.hold_data) && !q.th_hold) else $error("result not latched"); // RULE15
    chk_prev_result: assert property (s_conv_start
        |-> q.shreg == {$past(q.sar), 1'b0}) else $error("frame not loaded with previous result"); // RULE16

endmodule : sarrd_top
`default_nettype wire

/* File: tb/sarrd_host.sv */
// sarrd_host: behavioural host with master clock, trigger, frame sync, receiver.
// assumes its tasks are called just after a rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none

module sarrd_host (
    input  wire logic        clk_i,    // system clock
    input  wire logic        sclk_i,   // serial clock from the block
    input  wire logic        sdat_i,   // serial data from the block
    input  wire logic        oe_i,     // block drives serial data
    output logic             mclk_o,   // master clock
    output logic             trig_n_o, // trigger, active low
    output logic             fsync_n_o, // frame sync, active low
    output logic [15:0]      rx_o,     // received bits, first bit on top
    output logic [4:0]       cnt_o     // bits received
);
    logic sclk_q;

    // free running 160 ns clock, phase unrelated to clk_i
    initial begin
        mclk_o = 1'b0;
        trig_n_o = 1'b1;
        fsync_n_o = 1'b1;
        rx_o = '0;
        cnt_o = '0;
        sclk_q = 1'b0;
        #7;
        forever #80 mclk_o = ~mclk_o;
    end

    // sample on the falling clock, mid-bit for the block
    always @(posedge clk_i) begin
        sclk_q <= sclk_i;
        if (sclk_q && !sclk_i && oe_i && cnt_o < 5'd16) begin
            rx_o  <= {rx_o[14:0], sdat_i};
            cnt_o <= cnt_o + 5'd1;
        end
    end

    // fall placed on the first clk_i rise after mclk falls so no clock rise is lost; low_n 0 keeps it low
    task automatic trig(input int low_n);
        @(negedge mclk_o);
        @(posedge clk_i);
        trig_n_o <= 1'b0;
        cnt_o    <= 5'd0;
        if (low_n > 0) begin
            repeat (low_n) @(posedge clk_i);
            trig_n_o <= 1'b1;
        end
    endtask : trig

    // raises the trigger on the next clk_i rise, closing a mode 1 frame
    task automatic untrig();
        @(posedge clk_i);
        trig_n_o <= 1'b1;
    endtask : untrig

    // frame sync level; a fall restarts reception
    task automatic frame(input logic lvl);
        @(posedge clk_i);
        fsync_n_o <= lvl;
        if (!lvl) cnt_o <= 5'd0;
    endtask : frame
endmodule : sarrd_host
`default_nettype wire

/* File: tb/tb.sv */
// tb: self-checking bench of sarrd_top driven by the behavioural host.
// assumes default conversion and acquisition parameters.
`timescale 1ns/1ps
`default_nettype none
`include "sarrd_params.svh"

module tb;
    localparam int PER = `SARRD_CONV_PERIODS;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  paddr = '0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic        mode = 1'b0;
    logic        standby_req = 1'b0;
    logic        nap_req = 1'b0;
    logic        pin_rst_n = 1'b1;
    logic [13:0] code = '0;
    logic        ovr = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, mclk, trig_n, fsync_n, sclk, sdat, oe, hold;
    logic        standby_flag, nap_flag, sclk_p, sdat_p, hold_p;
    logic [15:0] rx;
    logic [4:0]  cnt;
    int          miscompares = 0;
    int          compares = 0;
    int          rises, span, bad;

    always #10 sys_clk = ~sys_clk;

    sarrd_top dut_u (.sys_clk_i(sys_clk), .rstn_i(rstn), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .master_clock_i(mclk),
        .conversion_trigger_n_i(trig_n), .frame_sync_in_i(fsync_n),
        .serial_mode_select_i(mode), .standby_request_i(standby_req),
        .nap_request_i(nap_req), .adc_reset_n_i(pin_rst_n), .sample_code_i(code),
        .overrange_i(ovr), .serial_clock_out_o(sclk), .serial_data_out_o(sdat),
        .serial_data_oe_o(oe), .track_hold_o(hold), .standby_o(standby_flag),
        .nap_o(nap_flag));

    sarrd_host host_u (.clk_i(sys_clk), .sclk_i(sclk), .sdat_i(sdat), .oe_i(oe),
        .mclk_o(mclk), .trig_n_o(trig_n), .fsync_n_o(fsync_n), .rx_o(rx), .cnt_o(cnt));

    // link watch: clock rises in hold, hold span, data moving off a rise
    always @(posedge sys_clk) begin
        sclk_p <= sclk;
        sdat_p <= sdat;
        hold_p <= hold;
        if (sclk && !sclk_p && hold_p) rises <= rises + 1;
        if (hold) span <= span + 1;
        if (sdat !== sdat_p && !(sclk && !sclk_p)) bad <= bad + 1;
    end

    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic check_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_word

    // one apb transfer plus an idle cycle; entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // bounded wait for the hold output to reach v
    task automatic wait_hold(input logic v);
        int i;
        for (i = 0; i < 300 && hold !== v; i++) @(posedge sys_clk);
        if (i >= 300) begin
            miscompares++;
            summarize();
        end
    endtask : wait_hold

    // one conversion of v; pulse 0 leaves the trigger low for mode 1 framing
    task automatic convert(input logic [14:0] v, input int pulse);
        {ovr, code} <= v;
        rises = 0;
        span = 0;
        bad = 0;
        host_u.trig(pulse);
        wait_hold(1'b1);
        check_bit(hold, 1'b1, "hold after trigger");
        check_bit(oe, ~mode, "drive at start");
        wait_hold(1'b0);
        // let the link watch count the final rise before reading it
        @(posedge sys_clk);
        check_word(rises, PER, "clock rises per conversion");
        check_bit(span > 180 && span < 200, 1'b1, "hold span");
        check_word(bad, 0, "data moved off a rise");
    endtask : convert

    task automatic s_regs();
        logic [31:0] rd;
        logic        e;
        apb(1'b0, 8'h20, '0, rd, e);
        check_bit(e, 1'b1, "unmapped error");
        check_word(rd, 32'h0, "unmapped data");
        apb(1'b1, `SARRD_OFF_CTRL, 32'h1, rd, e);
        apb(1'b0, `SARRD_OFF_CTRL, '0, rd, e);
        check_word(rd, 32'h1, "control readback");
        apb(1'b1, `SARRD_OFF_TEST, 32'h5A3C, rd, e);
        apb(1'b0, `SARRD_OFF_TEST, '0, rd, e);
        check_word(rd, 32'h5A3C, "test data readback");
        host_u.trig(8);
        repeat (6) @(posedge sys_clk);
        check_bit(hold, 1'b0, "blocked trigger ignored");
        apb(1'b1, `SARRD_OFF_CTRL, '0, rd, e);
    endtask : s_regs

    task automatic s_mode1();
        logic [31:0] rd;
        logic        e;
        convert(15'h6A5C, 0);
        apb(1'b0, `SARRD_OFF_STATUS, '0, rd, e);
        check_word(rd[1:0], 32'h2, "acquisition after end");
        check_bit(hold, 1'b0, "track after end");
        apb(1'b0, `SARRD_OFF_RESULT, '0, rd, e);
        check_word(rd, 32'h6A5C, "held result");
        host_u.untrig();
        repeat (6) @(posedge sys_clk);
        check_bit(oe, 1'b0, "released after trigger rise");
        convert(15'h1234, 0);
        check_word(cnt, 32'd16, "frame length");
        check_word(rx, 32'hD4B8, "previous result framed");
        host_u.untrig();
        repeat (8) @(posedge sys_clk);
        apb(1'b0, `SARRD_OFF_COUNT, '0, rd, e);
        check_word(rd, 32'd2, "conversions counted");
    endtask : s_mode1

    task automatic s_mode2();
        int i;
        mode <= 1'b1;
        repeat (6) @(posedge sys_clk);
        convert(15'h0F0F, 6);
        host_u.frame(1'b0);
        repeat (6) @(posedge sys_clk);
        check_bit(oe, 1'b1, "driven after sync fall");
        for (i = 0; i < 200 && cnt !== 5'd16; i++) @(posedge sys_clk);
        check_word(cnt, 32'd16, "mode 2 frame length");
        check_word(rx, 32'h2468, "frame after sync fall");
        host_u.frame(1'b1);
        repeat (6) @(posedge sys_clk);
        check_bit(oe, 1'b0, "released after sync rise");
        mode <= 1'b0;
    endtask : s_mode2

    // standby, nap, then reset pin, each in mid-conversion
    task automatic s_power();
        int n;
        for (int k = 0; k < 3; k++) begin
            host_u.trig(0);
            wait_hold(1'b1);
            standby_req <= (k == 0);
            nap_req <= (k == 1);
            pin_rst_n <= (k != 2);
            repeat (6) @(posedge sys_clk);
            check_bit(hold, 1'b0, "conversion aborted");
            check_bit(oe, 1'b0, "output released");
            check_bit(k == 0 ? standby_flag : nap_flag, k < 2, "power flag");
            host_u.untrig();
            repeat (6) @(posedge sys_clk);
            host_u.trig(0);
            n = 0;
            for (int i = 0; i < 40; i++) begin
                @(posedge sys_clk);
                if (hold !== 1'b0 || (k < 2 && sclk !== 1'b0)) n++;
            end
            check_word(n, 0, "held off while requested");
            standby_req <= 1'b0;
            nap_req <= 1'b0;
            pin_rst_n <= 1'b1;
            host_u.untrig();
            repeat (8) @(posedge sys_clk);
        end
    endtask : s_power

    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        s_regs();
        s_mode1();
        s_mode2();
        s_power();
        summarize();
    end

    // hang guard
    initial begin
        #500us;
        miscompares++;
        summarize();
    end
endmodule : tb
`default_nettype wire
